//--- rtl/bdi_params.svh
// Offsets, field positions and reset values of the doorbell interrupt block
// How it works
// - Page-boundary mask bit 0 lets its request interrupt; 1 suppresses it.
// - Both page-boundary masks reset to the printed value 0FFFFFFFh.
// - Ones written to clear view low half clear primary request bits.
// - Ones written to clear view high half clear secondary request bits.
// - Clear and set views read request bits; all requests reset to zero.
// - Ones written to set view low half set primary request bits.
// - Ones written to set view high half set secondary request bits.
// - Ones written to primary clear-mask clear those bits; reads show mask.
// - Clear-mask 0 permits clearing, 1 blocks it; resets to all ones.
// - Secondary clear-mask gates secondary clearing the same way.
// - Last-doubleword page transfer sets page request, raising secondary IRQ.
// - Set-mask 0 permits setting a request, 1 blocks it; resets ones.
`ifndef BDI_PARAMS_SVH
`define BDI_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define BDI_OFS_PB_REQ_LO  8'h58
`define BDI_OFS_PB_REQ_HI  8'h5C
`define BDI_OFS_PB_MASK_LO 8'h60
`define BDI_OFS_PB_MASK_HI 8'h64
`define BDI_OFS_REQ_CLEAR  8'h70
`define BDI_OFS_REQ_SET    8'h74
`define BDI_OFS_CLR_GATE   8'h78
`define BDI_OFS_SET_GATE   8'h7C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BDI_PRI_MSB 15
`define BDI_PRI_LSB 0
`define BDI_SEC_MSB 31
`define BDI_SEC_LSB 16

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BDI_RST_PB_MASK  32'h0FFFFFFF
`define BDI_RST_PB_REQ   32'h00000000
`define BDI_RST_REQ      16'h0000
`define BDI_RST_GATE     16'hFFFF

`endif

//--- rtl/bdi_pkg.sv
// Shared types of the doorbell interrupt block
package bdi_pkg;
  typedef logic [7:0]  bdi_addr_t;
  typedef logic [31:0] bdi_word_t;
  typedef logic [15:0] bdi_half_t;
endpackage : bdi_pkg

//--- rtl/bdi_w1_bank.sv
// Bank of sticky bits with per-bit set and clear strobes
`timescale 1ns/1ps
module bdi_w1_bank #(
  parameter int             W   = 16,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] q
);
  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Set beats clear so an event in the clearing cycle is never lost
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= RST;
    end else begin
      q <= (q & ~clr_i) | set_i;
    end
  end
endmodule : bdi_w1_bank

//--- rtl/bdi_irq_regs.sv
// Doorbell and page-boundary interrupt registers of the bridge
`timescale 1ns/1ps
`include "bdi_params.svh"
module bdi_irq_regs (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic        CSR_WR,
  input  wire logic        CSR_RD,
  input  wire logic [7:0]  CSR_ADDR,
  input  wire logic [31:0] CSR_WDATA,
  input  wire logic [31:0] PB_HIT_LO,
  input  wire logic [31:0] PB_HIT_HI,
  input  wire logic [31:0] SET_GATE_OPEN,
  output logic      [31:0] CSR_RDATA,
  output logic             CSR_RVALID,
  output logic             PRI_IRQ,
  output logic             SEC_IRQ,
  output logic             LEGACY_INTERRUPT_A_N
);
  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input bdi_pkg::bdi_addr_t a,
                               input bdi_pkg::bdi_addr_t ofs);
    hit = (a == ofs);
  endfunction : hit

  logic wr_pbr_lo;
  logic wr_pbr_hi;
  logic wr_pbm_lo;
  logic wr_pbm_hi;
  logic wr_clr;
  logic wr_set;
  logic wr_cgate;
  logic wr_sgate;

  assign wr_pbr_lo = CSR_WR && hit(CSR_ADDR, `BDI_OFS_PB_REQ_LO);
  assign wr_pbr_hi = CSR_WR && hit(CSR_ADDR, `BDI_OFS_PB_REQ_HI);
  assign wr_pbm_lo = CSR_WR && hit(CSR_ADDR, `BDI_OFS_PB_MASK_LO);
  assign wr_pbm_hi = CSR_WR && hit(CSR_ADDR, `BDI_OFS_PB_MASK_HI);
  assign wr_clr    = CSR_WR && hit(CSR_ADDR, `BDI_OFS_REQ_CLEAR);
  assign wr_set    = CSR_WR && hit(CSR_ADDR, `BDI_OFS_REQ_SET);
  assign wr_cgate  = CSR_WR && hit(CSR_ADDR, `BDI_OFS_CLR_GATE);
  assign wr_sgate  = CSR_WR && hit(CSR_ADDR, `BDI_OFS_SET_GATE);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  bdi_pkg::bdi_word_t pb_req_lo;
  bdi_pkg::bdi_word_t pb_req_hi;
  bdi_pkg::bdi_word_t pb_mask_lo;
  bdi_pkg::bdi_word_t pb_mask_hi;
  bdi_pkg::bdi_word_t req;
  bdi_pkg::bdi_word_t clr_gate;
  bdi_pkg::bdi_word_t set_gate;
  bdi_pkg::bdi_word_t req_set;
  bdi_pkg::bdi_word_t req_clr;

  // Both halves share one word: low primary, high secondary
  assign req_set = wr_set ? (CSR_WDATA & ~set_gate) : '0;
  assign req_clr = wr_clr ? (CSR_WDATA & ~clr_gate) : '0;

  bdi_w1_bank #(.W(32), .RST(`BDI_RST_PB_REQ)) u_pbr_lo (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .set_i (PB_HIT_LO),
    .clr_i (wr_pbr_lo ? CSR_WDATA : '0),
    .q     (pb_req_lo)
  );
  bdi_w1_bank #(.W(32), .RST(`BDI_RST_PB_REQ)) u_pbr_hi (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .set_i (PB_HIT_HI),
    .clr_i (wr_pbr_hi ? CSR_WDATA : '0),
    .q     (pb_req_hi)
  );
  // Mask bits can only be opened by software; reset closes bits 27:0 again
  bdi_w1_bank #(.W(32), .RST(`BDI_RST_PB_MASK)) u_pbm_lo (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .set_i ('0),
    .clr_i (wr_pbm_lo ? CSR_WDATA : '0),
    .q     (pb_mask_lo)
  );
  bdi_w1_bank #(.W(32), .RST(`BDI_RST_PB_MASK)) u_pbm_hi (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .set_i ('0),
    .clr_i (wr_pbm_hi ? CSR_WDATA : '0),
    .q     (pb_mask_hi)
  );
  bdi_w1_bank #(.W(32), .RST({`BDI_RST_REQ, `BDI_RST_REQ})) u_req (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .set_i (req_set),
    .clr_i (req_clr),
    .q     (req)
  );
  bdi_w1_bank #(.W(32), .RST({`BDI_RST_GATE, `BDI_RST_GATE})) u_cgate (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .set_i ('0),
    .clr_i (wr_cgate ? CSR_WDATA : '0),
    .q     (clr_gate)
  );
  // Software can only close the set gate; opening comes from the side port
  bdi_w1_bank #(.W(32), .RST({`BDI_RST_GATE, `BDI_RST_GATE})) u_sgate (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .set_i (wr_sgate ? CSR_WDATA : '0),
    .clr_i (SET_GATE_OPEN),
    .q     (set_gate)
  );

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      CSR_RDATA  <= 32'h00000000;
      CSR_RVALID <= 1'b0;
    end else begin
      CSR_RVALID <= CSR_RD;
      if (!CSR_RD) begin
        CSR_RDATA <= 32'h00000000;
      end else begin
        case (CSR_ADDR)
          `BDI_OFS_PB_REQ_LO:  CSR_RDATA <= pb_req_lo;
          `BDI_OFS_PB_REQ_HI:  CSR_RDATA <= pb_req_hi;
          `BDI_OFS_PB_MASK_LO: CSR_RDATA <= pb_mask_lo;
          `BDI_OFS_PB_MASK_HI: CSR_RDATA <= pb_mask_hi;
          `BDI_OFS_REQ_CLEAR:  CSR_RDATA <= req;
          `BDI_OFS_REQ_SET:    CSR_RDATA <= req;
          `BDI_OFS_CLR_GATE:   CSR_RDATA <= clr_gate;
          `BDI_OFS_SET_GATE:   CSR_RDATA <= set_gate;
          default:             CSR_RDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------------
  logic pri_any;
  logic sec_any;
  logic pb_any;

  assign pb_any  = (|(pb_req_lo & ~pb_mask_lo))
                 | (|(pb_req_hi & ~pb_mask_hi));
  assign pri_any = |req[`BDI_PRI_MSB:`BDI_PRI_LSB];
  assign sec_any = |req[`BDI_SEC_MSB:`BDI_SEC_LSB] | pb_any;

  // Registered so the pins never glitch while the sources change
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      PRI_IRQ              <= 1'b0;
      SEC_IRQ              <= 1'b0;
      LEGACY_INTERRUPT_A_N <= 1'b1;
    end else begin
      PRI_IRQ              <= pri_any;
      SEC_IRQ              <= sec_any;
      LEGACY_INTERRUPT_A_N <= ~sec_any;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  bdi_pkg::bdi_word_t set_eff;
  bdi_pkg::bdi_word_t clr_eff;
  bdi_pkg::bdi_word_t held;
  bdi_pkg::bdi_word_t cg_wr;
  logic               pb_open;

  assign set_eff = CSR_WDATA & ~set_gate;
  assign clr_eff = CSR_WDATA & ~clr_gate;
  assign held    = req & clr_gate;
  assign cg_wr   = CSR_WDATA;
  assign pb_open = |(pb_req_lo & ~pb_mask_lo);

  a_pb_mask_gate: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    pb_open |=> SEC_IRQ && !LEGACY_INTERRUPT_A_N)
    else $error("unmasked page request gave no secondary interrupt");
  a_pb_mask_reset: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    $rose(RESETN) |-> pb_mask_lo == 32'h0FFFFFFF
      && pb_mask_hi == 32'h0FFFFFFF)
    else $error("page mask reset value wrong");
  a_pri_clear_ones: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    wr_clr |=> (req[15:0] & $past(clr_eff[15:0])) == 16'h0000)
    else $error("primary request bit survived a clear");
  a_sec_clear_ones: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    wr_clr |=> (req[31:16] & $past(clr_eff[31:16])) == 16'h0000)
    else $error("secondary request bit survived a clear");
  a_req_reset_zero: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    $rose(RESETN) |-> req == 32'h00000000 && !PRI_IRQ)
    else $error("request bits not zero after reset");
  a_pri_set_ones: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    wr_set |=> (req[15:0] & $past(set_eff[15:0]))
      == $past(set_eff[15:0])
      ##1 PRI_IRQ || $past(set_eff[15:0], 2) == 16'h0000)
    else $error("primary set did not take effect");
  a_sec_set_ones: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    wr_set |=> (req[31:16] & $past(set_eff[31:16]))
      == $past(set_eff[31:16]))
    else $error("secondary set did not take effect");
  a_clr_gate_write: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    wr_cgate |=> (clr_gate & $past(cg_wr)) == 32'h00000000)
    else $error("clear-mask bit not cleared by write");
  a_clr_gate_block: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    wr_clr |=> (req & $past(held)) == $past(held))
    else $error("gated request bit was cleared");
  a_set_gate_block: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    wr_set && set_gate == 32'hFFFFFFFF && req == 32'h00000000
      |=> req == 32'h00000000)
    else $error("closed set gate let a request through");
  a_pb_hit_sets: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    PB_HIT_LO != 32'h00000000 |=> (pb_req_lo & $past(PB_HIT_LO))
      == $past(PB_HIT_LO))
    else $error("page hit did not set its request");
  a_irq_idle_low: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    !pri_any && !sec_any |=> !PRI_IRQ && !SEC_IRQ)
    else $error("interrupt held with no pending request");
endmodule : bdi_irq_regs

//--- bench/bdi_host_model.sv
// Host model driving the register port and the page-hit events
`timescale 1ns/1ps
module bdi_host_model (
  input  wire logic          clk,
  input  wire logic [31:0]   csr_rdata,
  input  wire logic          csr_rvalid,
  output bdi_pkg::bdi_word_t pb_hit_lo,
  output bdi_pkg::bdi_word_t pb_hit_hi,
  output bdi_pkg::bdi_word_t set_gate_open,
  output bdi_pkg::bdi_word_t csr_wdata,
  output bdi_pkg::bdi_addr_t csr_addr,
  output logic               csr_wr,
  output logic               csr_rd
);
  // ----------------------------------------------------------------
  // Idle state
  // ----------------------------------------------------------------
  initial begin
    csr_wr        = 1'h0;
    csr_rd        = 1'h0;
    csr_addr      = 8'h00;
    csr_wdata     = 32'h00000000;
    pb_hit_lo     = 32'h00000000;
    pb_hit_hi     = 32'h00000000;
    set_gate_open = 32'h00000000;
  end
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Released lines show the inverse so stale values never pass as good
  task automatic wr(input bdi_pkg::bdi_addr_t a, input bdi_pkg::bdi_word_t d);
    @(posedge clk);
    #1;
    csr_wr    = 1'h1;
    csr_addr  = a;
    csr_wdata = d;
    @(posedge clk);
    #1;
    csr_wr    = 1'h0;
    csr_addr  = ~a;
    csr_wdata = ~d;
  endtask : wr
  task automatic rd(input bdi_pkg::bdi_addr_t a, output logic [31:0] d,
                    output logic v);
    @(posedge clk);
    #1;
    csr_rd   = 1'h1;
    csr_addr = a;
    @(posedge clk);
    #1;
    d        = csr_rdata;
    v        = csr_rvalid;
    csr_rd   = 1'h0;
    csr_addr = ~a;
  endtask : rd
  task automatic pulse(input bdi_pkg::bdi_word_t lo, input bdi_pkg::bdi_word_t hi,
                       input bdi_pkg::bdi_word_t gate);
    @(posedge clk);
    #1;
    pb_hit_lo     = lo;
    pb_hit_hi     = hi;
    set_gate_open = gate;
    @(posedge clk);
    #1;
    pb_hit_lo     = 32'h00000000;
    pb_hit_hi     = 32'h00000000;
    set_gate_open = 32'h00000000;
  endtask : pulse
endmodule : bdi_host_model

//--- bench/testbench.sv
// Self-checking testbench of the doorbell interrupt registers
`timescale 1ns/1ps
module testbench;
  logic clk, resetn, pri_irq, sec_irq, leg_n, csr_wr, csr_rd, rvalid;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, hit_lo, hit_hi, gate;
  int          fails, n_compared;
  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  bdi_irq_regs dut_u (.SYS_CLK(clk), .RESETN(resetn), .CSR_WR(csr_wr),
    .CSR_RD(csr_rd), .CSR_ADDR(addr), .CSR_WDATA(wdata), .PB_HIT_LO(hit_lo),
    .PB_HIT_HI(hit_hi), .SET_GATE_OPEN(gate), .CSR_RDATA(rdata),
    .CSR_RVALID(rvalid), .PRI_IRQ(pri_irq), .SEC_IRQ(sec_irq),
    .LEGACY_INTERRUPT_A_N(leg_n));
  bdi_host_model host_u (.clk(clk), .csr_rdata(rdata), .csr_rvalid(rvalid),
    .pb_hit_lo(hit_lo), .pb_hit_hi(hit_hi), .set_gate_open(gate),
    .csr_wdata(wdata), .csr_addr(addr), .csr_wr(csr_wr), .csr_rd(csr_rd));
  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        v;
    host_u.rd(a, d, v);
    chk({31'h0, v}, 32'h1);
    chk(d, exp);
  endtask : rchk
  task automatic irqs(input logic p, input logic s);
    chk({31'h0, pri_irq}, {31'h0, p});
    chk({31'h0, sec_irq}, {31'h0, s});
    chk({31'h0, leg_n}, {31'h0, ~s});
  endtask : irqs
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rchk(8'h60, 32'h0FFFFFFF);
    rchk(8'h64, 32'h0FFFFFFF);
    rchk(8'h70, 32'h00000000);
    rchk(8'h74, 32'h00000000);
    rchk(8'h78, 32'hFFFFFFFF);
    rchk(8'h68, 32'h00000000);
    rchk(8'h58, 32'h00000000);
    rchk(8'h5C, 32'h00000000);
    rchk(8'h7C, 32'hFFFFFFFF);
    irqs(1'h0, 1'h0);
    $display("test reset values done");
  endtask : t_reset
  task automatic t_set;
    host_u.wr(8'h74, 32'h00010001);
    rchk(8'h70, 32'h00000000);
    host_u.pulse(32'h0, 32'h0, 32'h00010001);
    host_u.wr(8'h74, 32'h00010001);
    rchk(8'h70, 32'h00010001);
    rchk(8'h74, 32'h00010001);
    irqs(1'h1, 1'h1);
    $display("test doorbell set done");
  endtask : t_set
  task automatic t_clear;
    host_u.wr(8'h70, 32'h00010001);
    rchk(8'h70, 32'h00010001);
    host_u.wr(8'h78, 32'h00010001);
    rchk(8'h78, 32'hFFFEFFFE);
    host_u.wr(8'h70, 32'h00000001);
    rchk(8'h70, 32'h00010000);
    irqs(1'h0, 1'h1);
    host_u.wr(8'h70, 32'h00010000);
    rchk(8'h70, 32'h00000000);
    irqs(1'h0, 1'h0);
    $display("test doorbell clear done");
  endtask : t_clear
  task automatic t_page;
    host_u.pulse(32'h80000000, 32'h0, 32'h0);
    @(posedge clk);
    #1;
    irqs(1'h0, 1'h1);
    rchk(8'h58, 32'h80000000);
    host_u.wr(8'h58, 32'h80000000);
    rchk(8'h58, 32'h00000000);
    irqs(1'h0, 1'h0);
    host_u.pulse(32'h0, 32'h00000001, 32'h0);
    rchk(8'h5C, 32'h00000001);
    irqs(1'h0, 1'h0);
    host_u.wr(8'h64, 32'h00000001);
    rchk(8'h64, 32'h0FFFFFFE);
    irqs(1'h0, 1'h1);
    $display("test page boundary done");
  endtask : t_page
  task automatic t_gates;
    logic [31:0] d;
    logic        v;
    rchk(8'h7C, 32'hFFFEFFFE);
    host_u.wr(8'h7C, 32'h00010001);
    rchk(8'h7C, 32'hFFFFFFFF);
    host_u.wr(8'h74, 32'h00010001);
    rchk(8'h74, 32'h00000000);
    host_u.wr(8'h5C, 32'h00000001);
    rchk(8'h5C, 32'h00000000);
    irqs(1'h0, 1'h0);
    host_u.wr(8'h60, 32'h00000001);
    rchk(8'h60, 32'h0FFFFFFE);
    // Page event and its clear in one cycle: the event must survive
    fork
      host_u.pulse(32'h00000001, 32'h0, 32'h0);
      host_u.wr(8'h58, 32'h00000001);
    join
    @(posedge clk);
    #1;
    irqs(1'h0, 1'h1);
    host_u.rd(8'h58, d, v);
    chk({31'h0, v}, 32'h1);
    chk(d, 32'h00000001);
    @(posedge clk);
    #1;
    chk(rdata, 32'h00000000);
    chk({31'h0, rvalid}, 32'h0);
    $display("test gates done");
  endtask : t_gates
  task automatic t_rerst;
    @(posedge clk);
    #1;
    resetn = 1'h0;
    repeat (2) @(posedge clk);
    #1;
    resetn = 1'h1;
    irqs(1'h0, 1'h0);
    t_reset();
    $display("test mid-run reset done");
  endtask : t_rerst
  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic results;
    $display("fails=%0d compared=%0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  always #5 clk = ~clk;
  // Whole run needs about 110 cycles; 600 leaves a wide margin
  initial begin
    #6000;
    fails++;
    results();
  end
  initial begin
    clk        = 1'h0;
    resetn     = 1'h0;
    fails      = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    #1;
    resetn = 1'h1;
    t_reset();
    t_set();
    t_clear();
    t_page();
    t_gates();
    t_rerst();
    results();
  end
endmodule : testbench
